// File: verilog/rst_ctrl_pkg.sv
// Constants, encodings and reset values for the reset and RAM back-up controller
package rst_ctrl_pkg;

    // ==========================================================
    // Widths
    localparam int unsigned PAGE_W   = 6;
    localparam int unsigned ADDR_W   = 7;
    localparam int unsigned NIB_W    = 4;
    localparam int unsigned SER_W    = 5;
    localparam int unsigned OP_W     = 3;
    localparam int unsigned SEL_W    = 3;
    localparam int unsigned FLAG_N   = 8;
    localparam int unsigned PIN_N    = 4;

    // ==========================================================
    // Start vector after any reset or wakeup
    localparam logic [PAGE_W-1:0] START_PAGE = 6'h00;
    localparam logic [ADDR_W-1:0] START_ADDR = 7'h00;

    // ==========================================================
    // Instruction codes seen on the decode port
    localparam logic [OP_W-1:0] OP_OTHER       = 3'h0;
    localparam logic [OP_W-1:0] OP_ARM         = 3'h1;
    localparam logic [OP_W-1:0] OP_POWERDOWN   = 3'h2;
    localparam logic [OP_W-1:0] OP_SW_RESET    = 3'h3;
    localparam logic [OP_W-1:0] OP_WRITE_REG   = 3'h4;
    localparam logic [OP_W-1:0] OP_IRQ_ENABLE  = 3'h5;
    localparam logic [OP_W-1:0] OP_IRQ_DISABLE = 3'h6;
    localparam logic [OP_W-1:0] OP_CLEAR_FLAG  = 3'h7;

    // ==========================================================
    // Register selects for OP_WRITE_REG
    localparam logic [SEL_W-1:0] SEL_IRQ_EN_A = 3'h0;
    localparam logic [SEL_W-1:0] SEL_IRQ_EN_B = 3'h1;
    localparam logic [SEL_W-1:0] SEL_EXT_A    = 3'h2;
    localparam logic [SEL_W-1:0] SEL_EXT_B    = 3'h3;
    localparam logic [SEL_W-1:0] SEL_TIMER6   = 3'h4;
    localparam logic [SEL_W-1:0] SEL_CLKDIV   = 3'h5;
    localparam logic [SEL_W-1:0] SEL_OSCSTOP  = 3'h6;
    localparam logic [SEL_W-1:0] SEL_SERIAL   = 3'h7;

    // ==========================================================
    // Flag vector bit positions
    localparam int unsigned FLG_EXT_A  = 0;
    localparam int unsigned FLG_EXT_B  = 1;
    localparam int unsigned FLG_TMR1   = 2;
    localparam int unsigned FLG_TMR2   = 3;
    localparam int unsigned FLG_TMR3   = 4;
    localparam int unsigned FLG_TMR4   = 5;
    localparam int unsigned FLG_WDOG_A = 6;
    localparam int unsigned FLG_WDOG_B = 7;

    // ==========================================================
    // Reset values
    localparam logic [NIB_W-1:0]  RST_IRQ_EN  = 4'h0;
    localparam logic [NIB_W-1:0]  RST_EXT     = 4'h0;
    localparam logic [NIB_W-1:0]  RST_TIMER6  = 4'h0;
    localparam logic [NIB_W-1:0]  RST_CLKDIV  = 4'hF;
    localparam logic              RST_OSCSTOP = 1'h0;
    localparam logic [SER_W-1:0]  RST_SERIAL  = 5'h00;
    localparam logic [FLAG_N-1:0] RST_FLAGS   = 8'h00;
    localparam logic              RST_GIE     = 1'h0;
    localparam logic              RST_WDOG_EN = 1'h1;
    localparam logic              BFLAG_COLD  = 1'h0;
    localparam logic              BFLAG_WARM  = 1'h1;

    // Synchroniser reset: reset pin idles high, the rest idle low
    localparam logic [PIN_N-1:0]  SYNC_RST    = 4'h1;
    localparam int unsigned PIN_RESET_N = 0;
    localparam int unsigned PIN_DET_EN  = 1;
    localparam int unsigned PIN_SUPPLY  = 2;
    localparam int unsigned PIN_WAKE    = 3;

    // Operating state
    typedef enum logic { ST_RUN, ST_BACKUP } mode_t;

endpackage : rst_ctrl_pkg

// File: verilog/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int unsigned       W       = 1,
    parameter logic [W-1:0]      RST_VAL = '0
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic [W-1:0]    async_in,
    output logic      [W-1:0]    sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // ==========================================================
    // Next values: first stage only feeds the second
    always_comb
    begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // Registered stages, idle level under reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule : pin_sync

`default_nettype wire

// File: verilog/reset_state_and_ram_backup_ctrl.sv
// Reset state, voltage drop reset and RAM back-up control for a 4-bit core
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Every reset restarts execution at address 0 of page 0.
// - No instruction write lands on reset values through the release; flag_set can still set flags then.
// - Reset clears the global interrupt enable.
// - Reset clears the back-up flag and both external request flags.
// - Reset zeroes both interrupt source enable registers.
// - Reset zeroes both external interrupt control registers.
// - Reset clears the four timer request flags.
// - Reset clears both watchdog status flags.
// - Reset sets the watchdog enable flag.
// - Reset zeroes the sixth timer control register.
// - Reset sets all four clock divider control bits.
// - Reset clears the oscillator stop bit, oscillator keeps running.
// - Reset zeroes the serial mode register.
// - Shift, result and comparator registers get no defined reset value.
// - Enabled detector seeing low supply forces a system reset.
// - Detector enable pin alone gates the detector, running or backed up.
// - Back-up entered only when power-down directly follows the arming instruction.
// - Power-down without arming right before acts as a no-operation.
// - Back-up stops the oscillator, keeps RAM and keeps reset logic alive.
// - Wakeup from back-up restarts at 0 with back-up flag set.
// - Pin, watchdog, detector and software resets are cold, flag cleared.
module reset_state_and_ram_backup_ctrl (
    input  wire logic                                  clk,
    input  wire logic                                  rst,
    input  wire logic                                  reset_pin_n,
    input  wire logic                                  detector_enable_pin,
    input  wire logic                                  supply_low,
    input  wire logic                                  wakeup,
    input  wire logic                                  watchdog_timeout,
    input  wire logic                                  instr_valid,
    input  wire logic [rst_ctrl_pkg::OP_W-1:0]         instr_op,
    input  wire logic [rst_ctrl_pkg::SEL_W-1:0]        reg_sel,
    input  wire logic [rst_ctrl_pkg::SER_W-1:0]        reg_wdata,
    input  wire logic [rst_ctrl_pkg::FLAG_N-1:0]       flag_set,
    output logic                                       core_hold,
    output logic                                       pc_load,
    output logic [rst_ctrl_pkg::PAGE_W-1:0]            start_page,
    output logic [rst_ctrl_pkg::ADDR_W-1:0]            start_addr,
    output logic                                       backup_mode,
    output logic                                       osc_halt,
    output logic                                       backup_flag,
    output logic                                       global_irq_enable,
    output logic                                       ext_irq_req_a,
    output logic                                       ext_irq_req_b,
    output logic                                       timer_one_irq_req,
    output logic                                       timer_two_irq_req,
    output logic                                       timer_three_irq_req,
    output logic                                       timer_four_irq_req,
    output logic                                       watchdog_status_a,
    output logic                                       watchdog_status_b,
    output logic                                       watchdog_enable_flag,
    output logic [rst_ctrl_pkg::NIB_W-1:0]             irq_source_enable_a,
    output logic [rst_ctrl_pkg::NIB_W-1:0]             irq_source_enable_b,
    output logic [rst_ctrl_pkg::NIB_W-1:0]             ext_irq_ctrl_a,
    output logic [rst_ctrl_pkg::NIB_W-1:0]             ext_irq_ctrl_b,
    output logic [rst_ctrl_pkg::NIB_W-1:0]             timer_ctrl_six,
    output logic [rst_ctrl_pkg::NIB_W-1:0]             clock_divider_ctrl,
    output logic                                       oscillator_stop_ctrl,
    output logic [rst_ctrl_pkg::SER_W-1:0]             serial_mode_ctrl
);

    // ==========================================================
    // Pin synchronisers
    logic [rst_ctrl_pkg::PIN_N-1:0] pins_async;
    logic [rst_ctrl_pkg::PIN_N-1:0] pins_sync;

    assign pins_async[rst_ctrl_pkg::PIN_RESET_N] = reset_pin_n;
    assign pins_async[rst_ctrl_pkg::PIN_DET_EN]  = detector_enable_pin;
    assign pins_async[rst_ctrl_pkg::PIN_SUPPLY]  = supply_low;
    assign pins_async[rst_ctrl_pkg::PIN_WAKE]    = wakeup;

    pin_sync #(
        .W       (rst_ctrl_pkg::PIN_N),
        .RST_VAL (rst_ctrl_pkg::SYNC_RST)
    ) u_pin_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    // ==========================================================
    // State
    rst_ctrl_pkg::mode_t                       mode_q;
    rst_ctrl_pkg::mode_t                       mode_d;
    logic                                      hold_q;
    logic                                      hold_d;
    logic                                      load_q;
    logic                                      load_d;
    logic                                      armed_q;
    logic                                      armed_d;
    logic                                      bflag_q;
    logic                                      bflag_d;
    logic                                      gie_q;
    logic                                      gie_d;
    logic                                      wden_q;
    logic                                      wden_d;
    logic [rst_ctrl_pkg::FLAG_N-1:0]           flags_q;
    logic [rst_ctrl_pkg::FLAG_N-1:0]           flags_d;
    logic [rst_ctrl_pkg::NIB_W-1:0]            ien_a_q;
    logic [rst_ctrl_pkg::NIB_W-1:0]            ien_a_d;
    logic [rst_ctrl_pkg::NIB_W-1:0]            ien_b_q;
    logic [rst_ctrl_pkg::NIB_W-1:0]            ien_b_d;
    logic [rst_ctrl_pkg::NIB_W-1:0]            ext_a_q;
    logic [rst_ctrl_pkg::NIB_W-1:0]            ext_a_d;
    logic [rst_ctrl_pkg::NIB_W-1:0]            ext_b_q;
    logic [rst_ctrl_pkg::NIB_W-1:0]            ext_b_d;
    logic [rst_ctrl_pkg::NIB_W-1:0]            tmr6_q;
    logic [rst_ctrl_pkg::NIB_W-1:0]            tmr6_d;
    logic [rst_ctrl_pkg::NIB_W-1:0]            clkdiv_q;
    logic [rst_ctrl_pkg::NIB_W-1:0]            clkdiv_d;
    logic                                      oscstop_q;
    logic                                      oscstop_d;
    logic [rst_ctrl_pkg::SER_W-1:0]            serial_q;
    logic [rst_ctrl_pkg::SER_W-1:0]            serial_d;

    // ==========================================================
    // Reset sources and instruction qualifiers
    logic det_reset;
    logic pin_reset;
    logic sw_reset;
    logic cold;
    logic warm;
    logic exec;
    logic [rst_ctrl_pkg::FLAG_N-1:0] clr_mask;

    // Detector gated by the enable pin only, in any mode
    assign det_reset = pins_sync[rst_ctrl_pkg::PIN_DET_EN] & pins_sync[rst_ctrl_pkg::PIN_SUPPLY];
    assign pin_reset = ~pins_sync[rst_ctrl_pkg::PIN_RESET_N];
    // Core executes only when released and awake, so no instruction lands during release
    assign exec      = instr_valid & ~hold_q & (mode_q == rst_ctrl_pkg::ST_RUN);
    assign sw_reset  = exec & (instr_op == rst_ctrl_pkg::OP_SW_RESET);
    assign cold      = pin_reset | det_reset | watchdog_timeout | sw_reset;
    assign warm      = (mode_q == rst_ctrl_pkg::ST_BACKUP) & pins_sync[rst_ctrl_pkg::PIN_WAKE] & ~cold;

    // Flag clear decode; a set in the same cycle wins
    always_comb
    begin
        clr_mask = '0;
        if (exec && instr_op == rst_ctrl_pkg::OP_CLEAR_FLAG)
        begin
            clr_mask[reg_wdata[rst_ctrl_pkg::SEL_W-1:0]] = 1'b1;
        end
    end

    // ==========================================================
    // Sequencing: hold, start pulse, arming and back-up entry
    always_comb
    begin
        mode_d  = mode_q;
        armed_d = armed_q;
        bflag_d = bflag_q;
        // Core held through any reset and through back-up until wakeup
        hold_d  = cold | ((mode_q == rst_ctrl_pkg::ST_BACKUP) & ~warm);
        load_d  = hold_q & ~hold_d;
        case (mode_q)
            rst_ctrl_pkg::ST_RUN:
            begin
                if (cold)
                begin
                    armed_d = 1'b0;
                    bflag_d = rst_ctrl_pkg::BFLAG_COLD;
                end
                else if (exec)
                begin
                    if (instr_op == rst_ctrl_pkg::OP_POWERDOWN && armed_q)
                    begin
                        mode_d  = rst_ctrl_pkg::ST_BACKUP;
                        armed_d = 1'b0;
                    end
                    else
                    begin
                        // Unarmed power-down falls through as a no-operation
                        armed_d = (instr_op == rst_ctrl_pkg::OP_ARM);
                    end
                end
            end
            rst_ctrl_pkg::ST_BACKUP:
            begin
                // Reset logic stays live while the oscillator is halted
                if (cold)
                begin
                    mode_d  = rst_ctrl_pkg::ST_RUN;
                    bflag_d = rst_ctrl_pkg::BFLAG_COLD;
                end
                else if (warm)
                begin
                    mode_d  = rst_ctrl_pkg::ST_RUN;
                    bflag_d = rst_ctrl_pkg::BFLAG_WARM;
                end
            end
            default:
            begin
                mode_d = rst_ctrl_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mode_q  <= rst_ctrl_pkg::ST_RUN;
            hold_q  <= 1'b1;
            load_q  <= 1'b0;
            armed_q <= 1'b0;
            bflag_q <= rst_ctrl_pkg::BFLAG_COLD;
        end
        else
        begin
            mode_q  <= mode_d;
            hold_q  <= hold_d;
            load_q  <= load_d;
            armed_q <= armed_d;
            bflag_q <= bflag_d;
        end
    end

    // ==========================================================
    // Control registers and request flags
    // A warm start reinitialises only what back-up does not retain
    always_comb
    begin
        gie_d     = gie_q;
        wden_d    = wden_q;
        flags_d   = (flags_q & ~clr_mask) | flag_set;
        ien_a_d   = ien_a_q;
        ien_b_d   = ien_b_q;
        ext_a_d   = ext_a_q;
        ext_b_d   = ext_b_q;
        tmr6_d    = tmr6_q;
        clkdiv_d  = clkdiv_q;
        oscstop_d = oscstop_q;
        serial_d  = serial_q;
        if (cold)
        begin
            gie_d     = rst_ctrl_pkg::RST_GIE;
            wden_d    = rst_ctrl_pkg::RST_WDOG_EN;
            flags_d   = rst_ctrl_pkg::RST_FLAGS;
            ien_a_d   = rst_ctrl_pkg::RST_IRQ_EN;
            ien_b_d   = rst_ctrl_pkg::RST_IRQ_EN;
            ext_a_d   = rst_ctrl_pkg::RST_EXT;
            ext_b_d   = rst_ctrl_pkg::RST_EXT;
            tmr6_d    = rst_ctrl_pkg::RST_TIMER6;
            clkdiv_d  = rst_ctrl_pkg::RST_CLKDIV;
            oscstop_d = rst_ctrl_pkg::RST_OSCSTOP;
            serial_d  = rst_ctrl_pkg::RST_SERIAL;
        end
        else if (warm)
        begin
            gie_d    = rst_ctrl_pkg::RST_GIE;
            wden_d   = rst_ctrl_pkg::RST_WDOG_EN;
            flags_d  = rst_ctrl_pkg::RST_FLAGS;
            ien_a_d  = rst_ctrl_pkg::RST_IRQ_EN;
            ien_b_d  = rst_ctrl_pkg::RST_IRQ_EN;
            clkdiv_d = rst_ctrl_pkg::RST_CLKDIV;
        end
        else if (exec)
        begin
            case (instr_op)
                rst_ctrl_pkg::OP_IRQ_ENABLE:  gie_d = 1'b1;
                rst_ctrl_pkg::OP_IRQ_DISABLE: gie_d = 1'b0;
                rst_ctrl_pkg::OP_WRITE_REG:
                begin
                    case (reg_sel)
                        rst_ctrl_pkg::SEL_IRQ_EN_A: ien_a_d   = reg_wdata[rst_ctrl_pkg::NIB_W-1:0];
                        rst_ctrl_pkg::SEL_IRQ_EN_B: ien_b_d   = reg_wdata[rst_ctrl_pkg::NIB_W-1:0];
                        rst_ctrl_pkg::SEL_EXT_A:    ext_a_d   = reg_wdata[rst_ctrl_pkg::NIB_W-1:0];
                        rst_ctrl_pkg::SEL_EXT_B:    ext_b_d   = reg_wdata[rst_ctrl_pkg::NIB_W-1:0];
                        rst_ctrl_pkg::SEL_TIMER6:   tmr6_d    = reg_wdata[rst_ctrl_pkg::NIB_W-1:0];
                        rst_ctrl_pkg::SEL_CLKDIV:   clkdiv_d  = reg_wdata[rst_ctrl_pkg::NIB_W-1:0];
                        rst_ctrl_pkg::SEL_OSCSTOP:  oscstop_d = reg_wdata[0];
                        rst_ctrl_pkg::SEL_SERIAL:   serial_d  = reg_wdata;
                        default:                    serial_d  = serial_q;
                    endcase
                end
                default:
                begin
                    gie_d = gie_q;
                end
            endcase
        end
    end

    // Power-on values match the cold-start values
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            gie_q     <= rst_ctrl_pkg::RST_GIE;
            wden_q    <= rst_ctrl_pkg::RST_WDOG_EN;
            flags_q   <= rst_ctrl_pkg::RST_FLAGS;
            ien_a_q   <= rst_ctrl_pkg::RST_IRQ_EN;
            ien_b_q   <= rst_ctrl_pkg::RST_IRQ_EN;
            ext_a_q   <= rst_ctrl_pkg::RST_EXT;
            ext_b_q   <= rst_ctrl_pkg::RST_EXT;
            tmr6_q    <= rst_ctrl_pkg::RST_TIMER6;
            clkdiv_q  <= rst_ctrl_pkg::RST_CLKDIV;
            oscstop_q <= rst_ctrl_pkg::RST_OSCSTOP;
            serial_q  <= rst_ctrl_pkg::RST_SERIAL;
        end
        else
        begin
            gie_q     <= gie_d;
            wden_q    <= wden_d;
            flags_q   <= flags_d;
            ien_a_q   <= ien_a_d;
            ien_b_q   <= ien_b_d;
            ext_a_q   <= ext_a_d;
            ext_b_q   <= ext_b_d;
            tmr6_q    <= tmr6_d;
            clkdiv_q  <= clkdiv_d;
            oscstop_q <= oscstop_d;
            serial_q  <= serial_d;
        end
    end

    // ==========================================================
    // Outputs, all from flops except the constant start vector
    assign core_hold            = hold_q;
    assign pc_load              = load_q;
    assign start_page           = rst_ctrl_pkg::START_PAGE;
    assign start_addr           = rst_ctrl_pkg::START_ADDR;
    assign backup_mode          = (mode_q == rst_ctrl_pkg::ST_BACKUP);
    assign osc_halt             = (mode_q == rst_ctrl_pkg::ST_BACKUP);
    assign backup_flag          = bflag_q;
    assign global_irq_enable    = gie_q;
    assign ext_irq_req_a        = flags_q[rst_ctrl_pkg::FLG_EXT_A];
    assign ext_irq_req_b        = flags_q[rst_ctrl_pkg::FLG_EXT_B];
    assign timer_one_irq_req    = flags_q[rst_ctrl_pkg::FLG_TMR1];
    assign timer_two_irq_req    = flags_q[rst_ctrl_pkg::FLG_TMR2];
    assign timer_three_irq_req  = flags_q[rst_ctrl_pkg::FLG_TMR3];
    assign timer_four_irq_req   = flags_q[rst_ctrl_pkg::FLG_TMR4];
    assign watchdog_status_a    = flags_q[rst_ctrl_pkg::FLG_WDOG_A];
    assign watchdog_status_b    = flags_q[rst_ctrl_pkg::FLG_WDOG_B];
    assign watchdog_enable_flag = wden_q;
    assign irq_source_enable_a  = ien_a_q;
    assign irq_source_enable_b  = ien_b_q;
    assign ext_irq_ctrl_a       = ext_a_q;
    assign ext_irq_ctrl_b       = ext_b_q;
    assign timer_ctrl_six       = tmr6_q;
    assign clock_divider_ctrl   = clkdiv_q;
    assign oscillator_stop_ctrl = oscstop_q;
    assign serial_mode_ctrl     = serial_q;

endmodule : reset_state_and_ram_backup_ctrl

`default_nettype wire

// File: verilog/_unused_placeholder_removed.sv
// Intentionally empty compilation unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: bench/rst_bkp_chk.sv
// Assertion checker for the reset and RAM back-up controller
`timescale 1ns/1ps
`default_nettype none
module rst_bkp_chk (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       detector_enable_pin,
    input wire logic       supply_low,
    input wire logic       wakeup,
    input wire logic       watchdog_timeout,
    input wire logic       instr_valid,
    input wire logic       core_hold,
    input wire logic       pc_load,
    input wire logic       backup_mode,
    input wire logic       osc_halt,
    input wire logic       backup_flag,
    input wire logic       global_irq_enable,
    input wire logic [2:0] instr_op,
    input wire logic [3:0] clock_divider_ctrl,
    input wire logic [5:0] start_page,
    input wire logic [6:0] start_addr
);
    // ==========
    // Instruction sequences
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_take(logic [2:0] op);
        instr_valid && instr_op == op && !core_hold && !backup_mode;
    endsequence
    // Idle gap included, since idle cycles must not cancel arming
    sequence s_pair(logic [2:0] op);
        s_take(op) ##1 !instr_valid ##1 s_take(rst_ctrl_pkg::OP_POWERDOWN);
    endsequence
    // ==========
    // Properties
    property p_pc_vec; pc_load |-> $past(core_hold) && !core_hold && {start_page, start_addr} == 13'h0000;
    endproperty
    a_pc_vec: assert property (p_pc_vec) else $error("bad start vector");
    property p_cold; $fell(rst) |-> !global_irq_enable && !backup_flag && clock_divider_ctrl == 4'hF;
    endproperty
    a_cold: assert property (p_cold) else $error("bad reset state");
    property p_arm_pd; s_pair(rst_ctrl_pkg::OP_ARM) |=> backup_mode ##1 core_hold;
    endproperty
    a_arm_pd: assert property (p_arm_pd) else $error("no back-up entry");
    property p_pd_nop; s_pair(rst_ctrl_pkg::OP_OTHER) |=> !backup_mode;
    endproperty
    a_pd_nop: assert property (p_pd_nop) else $error("unarmed back-up entry");
    property p_osc; osc_halt == backup_mode;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator halt mismatch");
    property p_det; (detector_enable_pin && supply_low) [*3] |-> ##[1:3] core_hold;
    endproperty
    a_det: assert property (p_det) else $error("no detector reset");
    property p_wake; (backup_mode && wakeup) [*3] |-> ##[1:3] backup_flag && !backup_mode;
    endproperty
    a_wake: assert property (p_wake) else $error("no warm start");
    property p_wd; watchdog_timeout |=> core_hold && !backup_flag;
    endproperty
    a_wd: assert property (p_wd) else $error("no watchdog reset");
endmodule : rst_bkp_chk
bind reset_state_and_ram_backup_ctrl rst_bkp_chk u_chk (.*);
`default_nettype wire

// File: bench/reset_state_and_ram_backup_ctrl_tb.sv
// Self-checking bench for the reset and RAM back-up controller
`timescale 1ns/1ps
`default_nettype none
module reset_state_and_ram_backup_ctrl_tb;
    // ==========
    // Signals, register table rows: select, data, expected register vector
    logic clk = 1'b0, rst = 1'b1, reset_pin_n = 1'b1, wakeup = 1'b0, instr_valid = 1'b0;
    logic detector_enable_pin = 1'b0, supply_low = 1'b0, watchdog_timeout = 1'b0;
    logic [2:0] instr_op = 3'h0, reg_sel = 3'h0;
    logic [4:0] reg_wdata = 5'h00, serial_mode_ctrl;
    logic [7:0] flag_set = 8'h00;
    logic core_hold, pc_load, backup_mode, osc_halt, backup_flag, global_irq_enable, watchdog_enable_flag;
    logic ext_irq_req_a, ext_irq_req_b, watchdog_status_a, watchdog_status_b, oscillator_stop_ctrl;
    logic timer_one_irq_req, timer_two_irq_req, timer_three_irq_req, timer_four_irq_req;
    logic [5:0] start_page;
    logic [6:0] start_addr;
    logic [3:0] irq_source_enable_a, irq_source_enable_b, ext_irq_ctrl_a, ext_irq_ctrl_b, timer_ctrl_six;
    logic [3:0] clock_divider_ctrl;
    int err_total = 0, checked = 0;
    logic [29:0] regs_v;
    logic [10:0] flags_v;
    logic [37:0] rows [8] = '{{3'h0, 5'h0A, 30'h280003C0}, {3'h1, 5'h05, 30'h294003C0},
        {3'h2, 5'h03, 30'h294C03C0}, {3'h3, 5'h0C, 30'h294F03C0}, {3'h4, 5'h09, 30'h294F27C0},
        {3'h5, 5'h06, 30'h294F2580}, {3'h6, 5'h01, 30'h294F25A0}, {3'h7, 5'h15, 30'h294F25B5}};
    // Packed views keep each comparison to one line
    assign regs_v = {irq_source_enable_a, irq_source_enable_b, ext_irq_ctrl_a, ext_irq_ctrl_b,
        timer_ctrl_six, clock_divider_ctrl, oscillator_stop_ctrl, serial_mode_ctrl};
    assign flags_v = {global_irq_enable, backup_flag, ext_irq_req_a, ext_irq_req_b, timer_one_irq_req,
        timer_two_irq_req, timer_three_irq_req, timer_four_irq_req, watchdog_status_a, watchdog_status_b,
        watchdog_enable_flag};
    reset_state_and_ram_backup_ctrl DUT (.*);
    // 25 MHz clock
    always #20 clk = ~clk;
    // ==========
    // Tasks
    task chk(input logic [31:0] exp, got);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    // One instruction, then an idle cycle so strobes never toggle twice at one time
    task exec(input logic [2:0] op, s, input logic [4:0] d);
        @(negedge clk);
        instr_valid = 1'b1;
        instr_op = op;
        reg_sel = s;
        reg_wdata = d;
        @(negedge clk);
        instr_valid = 1'b0;
    endtask : exec
    // Bounded wait: pick 0 waits for pc_load, 1 for core_hold
    task wait_on(input logic pick);
        int i;
        for (i = 0; i < 40 && (pick ? core_hold : pc_load) !== 1'b1; i++) @(negedge clk);
        err_total += (i == 40);
        if (i == 40) test_done();
    endtask : wait_on
    task test_done();
        if (err_total == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    // ==========
    // Main sequence
    initial
    begin
        repeat (5) @(negedge clk);
        chk(30'h000003C0, regs_v);
        chk(11'h001, flags_v);
        rst = 1'b0;
        wait_on(1'b0);
        chk(13'h0000, {start_page, start_addr});
        chk(30'h000003C0, regs_v);
        for (int i = 0; i < 8; i++)
        begin
            exec(3'h4, rows[i][37:35], rows[i][34:30]);
            chk(rows[i][29:0], regs_v);
        end
        exec(3'h2, 3'h0, 5'h00);
        chk(1'b0, backup_mode);
        exec(3'h1, 3'h0, 5'h00);
        exec(3'h0, 3'h0, 5'h00);
        exec(3'h2, 3'h0, 5'h00);
        chk(1'b0, backup_mode);
        exec(3'h1, 3'h0, 5'h00);
        exec(3'h2, 3'h0, 5'h00);
        chk(2'b11, {backup_mode, osc_halt});
        wakeup = 1'b1;
        wait_on(1'b0);
        wakeup = 1'b0;
        chk(1'b1, backup_flag);
        chk(30'h000F27F5, regs_v);
        flag_set = 8'hFF;
        exec(3'h5, 3'h0, 5'h00);
        flag_set = 8'h00;
        chk(11'h7FF, flags_v);
        // Disable, clear one flag, then clear against a set: the set must win
        exec(3'h6, 3'h0, 5'h00);
        exec(3'h7, 3'h0, 5'h02);
        flag_set = 8'h08;
        exec(3'h7, 3'h0, 5'h03);
        flag_set = 8'h00;
        chk(11'h3BF, flags_v);
        reset_pin_n = 1'b0;
        wait_on(1'b1);
        reset_pin_n = 1'b1;
        wait_on(1'b0);
        chk(11'h001, flags_v);
        chk(30'h000003C0, regs_v);
        // Detector gated off first: a low supply alone must not reset
        supply_low = 1'b1;
        repeat (8) @(negedge clk);
        chk(1'b0, core_hold);
        detector_enable_pin = 1'b1;
        wait_on(1'b1);
        supply_low = 1'b0;
        wait_on(1'b0);
        watchdog_timeout = 1'b1;
        @(negedge clk);
        watchdog_timeout = 1'b0;
        chk(1'b1, core_hold);
        wait_on(1'b0);
        exec(3'h3, 3'h0, 5'h00);
        wait_on(1'b1);
        wait_on(1'b0);
        // Detector still resets from back-up, as a cold start
        exec(3'h1, 3'h0, 5'h00);
        exec(3'h2, 3'h0, 5'h00);
        chk(2'b10, {backup_mode, backup_flag});
        supply_low = 1'b1;
        repeat (4) @(negedge clk);
        chk(1'b0, backup_mode);
        supply_low = 1'b0;
        wait_on(1'b0);
        chk(1'b0, backup_flag);
        test_done();
    end
endmodule : reset_state_and_ram_backup_ctrl_tb
`default_nettype wire
